/* File: hw/lecc_top.sv */
// Lane 4..7 error counter control registers with their error counters, on APB
//
// Added by the designer: the APB slave port.
`default_nettype none
// Function
// R01: Bits [5:3] enable counting per lane.
// R02: Bit2 unexpected-K, bit1 invalid, bit0 disparity.
// R03: Enable field resets to 0x7, R/W.
// R04: Clear field [2:0], R/W, resets 0x7.
// R05: Lanes 4..7 at consecutive indices 0x484..0x487.
// R06: Set clear bit holds counter at zero.
// R07: Enabled, uncleared counter increments per error.
module lecc_top #(
  parameter int CNT_W = lecc_pkg::CNT_W
) (
  input  wire logic                  clk_sys_in,
  input  wire logic                  rst_b_in,
  input  wire lecc_pkg::lecc_apb_req_t apb_req_in,
  output logic                       pready_out,
  output logic                       pslverr_out,
  output logic [31:0]                prdata_out,
  input  wire logic [11:0]           lane_err_in,
  output logic [3:0][2:0][CNT_W-1:0] err_count_out
);
  typedef struct packed {
    lecc_pkg::lecc_lane_ctrl_t [3:0]  ctrl;
    logic [3:0][2:0][CNT_W-1:0]       cnt;
    logic [31:0]                      rdata;
    logic                             slverr;
    logic                             done;
  } lecc_state_t;

  lecc_state_t st;
  lecc_state_t next_st;
  logic        access;
  logic        hit;
  logic [1:0]  sel;
  logic [11:0] idx;

  // Errors come from the lane decoders on this clock; no synchroniser needed
  assign idx        = apb_req_in.paddr[13:2];
  assign access     = apb_req_in.psel && apb_req_in.penable;
  // One wait state: the answer comes from flops, never straight from decode
  assign pready_out = st.done;

  always_comb begin
    hit = 1'b1;
    sel = 2'h0;
    case (idx) // see R05
      lecc_pkg::IDX_LANE4: sel = 2'h0;
      lecc_pkg::IDX_LANE5: sel = 2'h1;
      lecc_pkg::IDX_LANE6: sel = 2'h2;
      lecc_pkg::IDX_LANE7: sel = 2'h3;
      default: hit = 1'b0;
    endcase
  end

  always_comb begin
    next_st        = st;
    // Response flops stand one cycle only, so idle cycles read back zero
    next_st.done   = 1'b0;
    next_st.rdata  = 32'h0000_0000;
    next_st.slverr = 1'b0;
    if (access && !st.done) begin
      // First access cycle: capture the answer, raise pready next cycle
      next_st.done   = 1'b1;
      next_st.slverr = !hit; // see R05
      if (hit && !apb_req_in.pwrite) begin
        next_st.rdata[lecc_pkg::ENA_LSB +: 3] = st.ctrl[sel].enable; // see R03
        next_st.rdata[lecc_pkg::CLR_LSB +: 3] = st.ctrl[sel].clear;  // see R04
      end
    end
    // Write lands only on the edge that completes the transfer
    if (access && st.done && hit && apb_req_in.pwrite) begin
      // Only low byte is meaningful; bits [7:6] are reserved and ignored
      next_st.ctrl[sel].enable = apb_req_in.pwdata[lecc_pkg::ENA_LSB +: 3]; // see R01
      next_st.ctrl[sel].clear  = apb_req_in.pwdata[lecc_pkg::CLR_LSB +: 3]; // see R04
    end
    for (int l = 0; l < lecc_pkg::NUM_LANES; l++) begin
      for (int t = 0; t < lecc_pkg::TYPES; t++) begin
        if (st.ctrl[l].clear[t]) begin
          next_st.cnt[l][t] = '0; // see R06
        end else if (st.ctrl[l].enable[t] && lane_err_in[l*3+t]) begin
          next_st.cnt[l][t] = st.cnt[l][t] + CNT_W'(1); // see R07 R02
        end
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      for (int l = 0; l < lecc_pkg::NUM_LANES; l++) begin
        st.ctrl[l].enable <= lecc_pkg::ENA_RESET; // see R03
        st.ctrl[l].clear  <= lecc_pkg::CLR_RESET; // see R04
      end
      st.cnt    <= '0;
      st.rdata  <= 32'h0000_0000;
      st.slverr <= 1'b0;
      st.done   <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // Data outputs straight from flops; costs one wait state per transfer
  assign prdata_out    = st.rdata;
  assign pslverr_out   = st.slverr;
  assign err_count_out = st.cnt;

  a_clear_holds: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in) // see R06
    st.ctrl[0].clear[0] |=> st.cnt[0][0] == '0)
    else $error("cleared counter not zero");
  a_disabled_keeps: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in) // see R07
    (!st.ctrl[1].enable[1] && !st.ctrl[1].clear[1]) |=> $stable(st.cnt[1][1]))
    else $error("disabled counter moved");
  a_count_step: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in) // see R07
    (st.ctrl[2].enable[2] && !st.ctrl[2].clear[2] && lane_err_in[8])
    |=> st.cnt[2][2] == $past(st.cnt[2][2]) + CNT_W'(1))
    else $error("counter did not step by one");
  a_write_enable: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in) // see R01
    (access && apb_req_in.pwrite && idx == lecc_pkg::IDX_LANE7 && pready_out)
    |=> st.ctrl[3].enable == $past(apb_req_in.pwdata[5:3]))
    else $error("enable field not written");
  a_write_clear: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in) // see R04
    (access && apb_req_in.pwrite && idx == lecc_pkg::IDX_LANE5 && pready_out)
    |=> st.ctrl[1].clear == $past(apb_req_in.pwdata[2:0]))
    else $error("clear field not written");
  a_read_back: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in) // see R03
    (access && !apb_req_in.pwrite && idx == lecc_pkg::IDX_LANE6 && !pready_out)
    |=> prdata_out == {26'h0, $past(st.ctrl[2].enable), $past(st.ctrl[2].clear)})
    else $error("read data mismatch");
  a_unmapped_err: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in) // see R05
    (access && idx == 12'h488 && !pready_out) |=> pslverr_out && prdata_out == 32'h0)
    else $error("unmapped access not flagged");
  a_no_write_keep: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in) // see R03
    !(access && pready_out) |=> $stable(st.ctrl))
    else $error("control changed without write");
  a_lane_type_map: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in) // see R02
    (st.ctrl[3].enable == 3'h4 && st.ctrl[3].clear == 3'h0 && lane_err_in[9] && !lane_err_in[11])
    |=> $stable(st.cnt[3][0]))
    else $error("wrong error type counted");

  // Bus handshake: one wait state, response flops idle at zero
  a_wait_state: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in) // see R05
    (access && !pready_out)
    |=> pready_out)
    else $error("pready missing after wait state");
  a_ready_once: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in) // see R05
    pready_out
    |=> !pready_out)
    else $error("pready held too long");
  a_ready_idle: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in) // see R05
    !access
    |=> !pready_out)
    else $error("pready without access");
  a_wait_no_write: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in) // see R03
    (access && !pready_out)
    |=> $stable(st.ctrl))
    else $error("write landed in wait state");
  a_unmapped_keep: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in) // see R05
    (access && !hit)
    |=> $stable(st.ctrl))
    else $error("unmapped write changed control");
  a_rdata_idle: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in) // see R03
    !pready_out
    |-> prdata_out == 32'h0)
    else $error("read data outside response");
  a_slverr_idle: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in) // see R05
    !pready_out
    |-> !pslverr_out)
    else $error("error outside response");
  a_reserved_zero: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in) // see R03
    pready_out
    |-> prdata_out[31:6] == 26'h0)
    else $error("reserved read bits not zero");
  a_mapped_no_err: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in) // see R05
    (access && hit && !pready_out)
    |=> !pslverr_out)
    else $error("mapped access flagged");
  a_write_ena4: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in) // see R01
    (access && apb_req_in.pwrite && idx == lecc_pkg::IDX_LANE4 && pready_out)
    |=> st.ctrl[0].enable == $past(apb_req_in.pwdata[5:3]))
    else $error("lane 4 enable not written");
  a_write_clr6: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in) // see R04
    (access && apb_req_in.pwrite && idx == lecc_pkg::IDX_LANE6 && pready_out)
    |=> st.ctrl[2].clear == $past(apb_req_in.pwdata[2:0]))
    else $error("lane 6 clear not written");
  a_read_lane4: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in) // see R04
    (access && !apb_req_in.pwrite && idx == lecc_pkg::IDX_LANE4 && !pready_out)
    |=> prdata_out[2:0] == $past(st.ctrl[0].clear))
    else $error("lane 4 clear read mismatch");

  // Counters
  a_clear_lane7: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in) // see R06
    st.ctrl[3].clear[2]
    |=> st.cnt[3][2] == '0)
    else $error("lane 7 counter not cleared");
  a_clear_lane5: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in) // see R06
    st.ctrl[1].clear[1]
    |=> st.cnt[1][1] == '0)
    else $error("lane 5 counter not cleared");
  a_disabled_lane4: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in) // see R07
    (!st.ctrl[0].enable[2] && !st.ctrl[0].clear[2])
    |=> $stable(st.cnt[0][2]))
    else $error("disabled lane 4 counter moved");
  a_no_error_keep: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in) // see R07
    (!lane_err_in[4] && !st.ctrl[1].clear[1])
    |=> $stable(st.cnt[1][1]))
    else $error("counter moved without error");
  a_count_lane4: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in) // see R02
    (st.ctrl[0].enable[0] && !st.ctrl[0].clear[0] && lane_err_in[0])
    |=> st.cnt[0][0] == $past(st.cnt[0][0]) + CNT_W'(1))
    else $error("lane 4 disparity counter did not step");

  c_count: cover property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    st.cnt[0][2] == CNT_W'(2));
  c_write: cover property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    access && apb_req_in.pwrite && hit);
  c_read: cover property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    access && !apb_req_in.pwrite && hit);
  c_unmapped: cover property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    access && !hit);
  c_wait: cover property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    access && !pready_out);
endmodule
`default_nettype wire

/* File: hw/lecc_pkg.sv */
// Package: register map, field layout and types for the lane error counter control block
`default_nettype none
package lecc_pkg;
  localparam int          NUM_LANES   = 4;
  localparam int          FIRST_LANE  = 4;
  localparam int          TYPES       = 3;
  // Printed offsets are word indices; bus byte address is four times the index
  localparam logic [11:0] IDX_LANE4   = 12'h484;
  localparam logic [11:0] IDX_LANE5   = 12'h485;
  localparam logic [11:0] IDX_LANE6   = 12'h486;
  localparam logic [11:0] IDX_LANE7   = 12'h487;
  localparam int          ADDR_W      = 14;
  localparam int          CTRL_W      = 8;
  localparam int          ENA_LSB     = 3;
  localparam int          CLR_LSB     = 0;
  localparam logic [2:0]  ENA_RESET   = 3'h7;
  localparam logic [2:0]  CLR_RESET   = 3'h7;
  localparam int          BIT_UNEXP_K = 2;
  localparam int          BIT_INVALID = 1;
  localparam int          BIT_DISP    = 0;
  localparam int          CNT_W       = 8;
  localparam logic [7:0]  CNT_ONE     = 8'h01;
  localparam logic [7:0]  CNT_ZERO    = 8'h00;

  typedef struct packed {
    logic [2:0] enable;
    logic [2:0] clear;
  } lecc_lane_ctrl_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [13:0] paddr;
    logic [31:0] pwdata;
  } lecc_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } lecc_apb_rsp_t;
endpackage
`default_nettype wire

/* File: sim/lane_error_counter_control_tb_top.sv */
// Self-checking bench for the lane 4..7 error counter control block
`default_nettype none
module lane_error_counter_control_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic                    clk_sys_in = 1'b0;
  logic                    rst_b_in   = 1'b0;
  lecc_pkg::lecc_apb_req_t req        = '0;
  logic                    pready;
  logic                    pslverr;
  logic [31:0]             prdata;
  logic [11:0]             lane_err   = 12'h000;
  logic [3:0][2:0][7:0]    cnt;
  logic [31:0]             seed       = 32'h195D36C6;
  int                      n_errors   = 0;
  int                      total_checks = 0;
  logic [5:0]              ctl [4]    = '{4{6'h3F}};
  logic [7:0]              exp_cnt [4][3] = '{default: 8'h00};
  logic [31:0]             rd;
  logic                    er;

  always #20 clk_sys_in = ~clk_sys_in;

  lecc_top u_dut (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .apb_req_in(req),
    .pready_out(pready), .pslverr_out(pslverr), .prdata_out(prdata),
    .lane_err_in(lane_err), .err_count_out(cnt));

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction

  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input string what, input logic [32:0] seen, input logic [32:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Waits on pready with a bound; zero wait states are not assumed
  task automatic apb(input logic w, input logic [11:0] idx, input logic [31:0] wd);
    int n;
    @(posedge clk_sys_in) req <= '{1'b1, 1'b0, w, {idx, 2'b00}, wd};
    @(posedge clk_sys_in) req.penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge clk_sys_in);
      if (pready === 1'b1) break;
    end
    if (n == 20) begin
      n_errors++;
      end_sim();
    end
    rd = prdata;
    er = pslverr;
    req <= '0;
  endtask

  // Clear wins over enable; disabled counters hold
  task automatic run_err(input int cyc);
    for (int i = 0; i < cyc; i++) begin
      @(posedge clk_sys_in);
      seed = xs(seed);
      lane_err <= seed[11:0];
      for (int l = 0; l < 4; l++)
        for (int t = 0; t < 3; t++)
          if (ctl[l][t]) exp_cnt[l][t] = 8'h00;
          else if (ctl[l][3+t] && seed[l*3+t]) exp_cnt[l][t]++;
    end
    @(posedge clk_sys_in) lane_err <= 12'h000;
    @(posedge clk_sys_in) #1;
    for (int l = 0; l < 4; l++)
      for (int t = 0; t < 3; t++)
        chk("err_count", {25'h0, cnt[l][t]}, {25'h0, exp_cnt[l][t]});
  endtask

  initial begin
    repeat (4) @(posedge clk_sys_in);
    rst_b_in <= 1'b1;
    for (int l = 0; l < 4; l++) begin
      apb(1'b0, lecc_pkg::IDX_LANE4 + 12'(l), 32'h0);
      chk("reset ctl", {er, rd}, {1'b0, 32'h3F});
    end
    run_err(10);
    $display("reset test done");
    apb(1'b1, 12'h488, 32'hFFFF_FFFF);
    chk("unmapped write", {er, rd}, {1'b1, 32'h0});
    apb(1'b0, 12'h483, 32'h0);
    chk("unmapped read", {er, rd}, {1'b1, 32'h0});
    $display("unmapped test done");
    for (int r = 0; r < 5; r++) begin
      for (int l = 0; l < 4; l++) begin
        seed = xs(seed);
        ctl[l] = r == 0 ? 6'h38 : r == 1 ? {seed[5:3], 3'h0} : r == 2 ? 6'h00 : seed[5:0];
        apb(1'b1, lecc_pkg::IDX_LANE4 + 12'(l), {seed[31:6], ctl[l]});
        apb(1'b0, lecc_pkg::IDX_LANE4 + 12'(l), 32'h0);
        chk("ctl readback", {er, rd}, {27'h0, ctl[l]});
        for (int t = 0; t < 3; t++) if (ctl[l][t]) exp_cnt[l][t] = 8'h00;
      end
      run_err(r == 1 ? 300 : 40);
      $display("count round %0d done", r);
    end
    end_sim();
  end
endmodule
`default_nettype wire
